// ### hw/cos_pkg.sv
// Purpose: Shared constants and carriers for the call operand-size selector.
// Assumes: 32-bit AXI4-Lite register bus, byte addresses below 0x20.
// Notes: Field layouts live in the packed structs below.
package cos_pkg;

  localparam int COS_ADDR_W = 8;
  localparam int COS_DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] COS_OFS_CTRL = 8'h00;
  localparam logic [7:0] COS_OFS_TARGET = 8'h04;
  localparam logic [7:0] COS_OFS_GATE_OFS = 8'h08;
  localparam logic [7:0] COS_OFS_IP = 8'h0C;
  localparam logic [7:0] COS_OFS_RESULT = 8'h10;
  localparam logic [7:0] COS_OFS_DEST = 8'h14;
  localparam logic [7:0] COS_OFS_RET_ADDR = 8'h18;

  // Reset values
  localparam logic [31:0] COS_RST_WORD = 32'h0000_0000;
  localparam logic COS_RST_READY = 1'b1;

  // Address limits and unit sizes
  localparam logic [31:0] COS_LIMIT_16 = 32'h0000_FFFF;
  localparam logic [2:0] COS_UNIT_16 = 3'h2;
  localparam logic [2:0] COS_UNIT_32 = 3'h4;

  // Bus responses
  localparam logic [1:0] COS_RESP_OKAY = 2'h0;
  localparam logic [1:0] COS_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    COS_KIND_PTR_CALL,
    COS_KIND_GATE_CALL,
    COS_KIND_INTERRUPT,
    COS_KIND_RETURN
  } cos_kind_e;

  typedef struct packed {
    logic [19:0] unused;
    logic [4:0] count;
    logic priv_change;
    logic stack_big;
    logic gate32;
    logic prefix;
    logic d_flag;
    cos_kind_e kind;
  } cos_ctrl_s;

  typedef struct packed {
    logic [16:0] unused;
    logic [6:0] copy_bytes;
    logic [2:0] stack_unit;
    logic valid;
    logic ret_unsafe;
    logic from_gate;
    logic sp32;
    logic op32;
  } cos_result_s;

endpackage

// ### hw/cos_size_resolve.sv
// Purpose: Operand-size choice from code segment flag, prefix and gate width.
// Assumes: Pure combinational, used inside the core clock domain.
// Notes: A gate always wins over flag and prefix.
`timescale 1ns/1ps
module cos_size_resolve
  import cos_pkg::*;
(
  // Selection inputs
  input wire logic i_use_gate,
  input wire logic i_gate32,
  input wire logic i_d_flag,
  input wire logic i_prefix,
  // Result
  output logic o_op32
);

  always_comb
  begin
    if (i_use_gate)
    begin
      o_op32 = i_gate32;
    end
    else
    begin
      o_op32 = i_d_flag ^ i_prefix;
    end
  end

endmodule // cos_size_resolve

// ### hw/cos_call_size_select.sv
// Purpose: Decodes operand size, stack width, destination and parameter copy for transfers.
// Assumes: AXI4-Lite master with at most one write and one read outstanding.
// Notes: Writing the control word starts a decode; results appear two cycles later.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module cos_call_size_select
  import cos_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  input wire logic [COS_ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  output logic o_awready,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  input wire logic [COS_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_wready,
  // AXI4-Lite write response
  output logic o_bvalid,
  output logic [1:0] o_bresp,
  input wire logic i_bready,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  input wire logic [COS_ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_arready,
  // AXI4-Lite read data
  output logic o_rvalid,
  output logic [COS_DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_rready
);

  logic aw_hold, w_hold, do_write, decode_req, use_gate, op32, read_hit, write_hit;
  logic [COS_ADDR_W-1:0] aw_addr;
  logic [3:0] w_strb;
  logic [31:0] w_data, target, gate_ofs, cur_ip, dest, ret_addr, next_dest, next_ret_addr, read_word;
  cos_ctrl_s ctrl;
  cos_result_s result, next_result;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign do_write = aw_hold && w_hold && !o_bvalid;
  assign write_hit = (aw_addr == COS_OFS_CTRL) || (aw_addr == COS_OFS_TARGET) ||
                     (aw_addr == COS_OFS_GATE_OFS) || (aw_addr == COS_OFS_IP) ||
                     (aw_addr == COS_OFS_RESULT) || (aw_addr == COS_OFS_DEST) ||
                     (aw_addr == COS_OFS_RET_ADDR);

  // Address and data taken in either order
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_awready <= COS_RST_READY;
      aw_hold <= 1'b0;
      aw_addr <= '0;
    end
    else if (o_awready && i_awvalid)
    begin
      o_awready <= 1'b0;
      aw_hold <= 1'b1;
      aw_addr <= i_awaddr;
    end
    else if (do_write)
    begin
      aw_hold <= 1'b0;
    end
    else if (o_bvalid && i_bready)
    begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_wready <= COS_RST_READY;
      w_hold <= 1'b0;
      w_data <= COS_RST_WORD;
      w_strb <= '0;
    end
    else if (o_wready && i_wvalid)
    begin
      o_wready <= 1'b0;
      w_hold <= 1'b1;
      w_data <= i_wdata;
      w_strb <= i_wstrb;
    end
    else if (do_write)
    begin
      w_hold <= 1'b0;
    end
    else if (o_bvalid && i_bready)
    begin
      o_wready <= 1'b1;
    end
  end

  // Response; read-only registers ignore writes but answer OKAY
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_bvalid <= 1'b0;
      o_bresp <= COS_RESP_OKAY;
    end
    else if (do_write)
    begin
      o_bvalid <= 1'b1;
      o_bresp <= write_hit ? COS_RESP_OKAY : COS_RESP_SLVERR;
    end
    else if (o_bvalid && i_bready)
    begin
      o_bvalid <= 1'b0;
    end
  end

  // Software-written inputs to the decode
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl <= cos_ctrl_s'(COS_RST_WORD);
      target <= COS_RST_WORD;
      gate_ofs <= COS_RST_WORD;
      cur_ip <= COS_RST_WORD;
      decode_req <= 1'b0;
    end
    else
    begin
      decode_req <= do_write && (aw_addr == COS_OFS_CTRL);
      if (do_write)
      begin
        case (aw_addr)
          COS_OFS_CTRL:
          begin
            ctrl <= cos_ctrl_s'(merge(32'(ctrl), w_data, w_strb));
            ctrl.unused <= '0;
          end
          COS_OFS_TARGET: target <= merge(target, w_data, w_strb);
          COS_OFS_GATE_OFS: gate_ofs <= merge(gate_ofs, w_data, w_strb);
          COS_OFS_IP: cur_ip <= merge(cur_ip, w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  assign use_gate = (ctrl.kind == COS_KIND_GATE_CALL) || (ctrl.kind == COS_KIND_INTERRUPT);

  cos_size_resolve u_resolve (
    .i_use_gate(use_gate),
    .i_gate32(ctrl.gate32),
    .i_d_flag(ctrl.d_flag),
    .i_prefix(ctrl.prefix),
    .o_op32(op32)
  );

  always_comb
  begin
    next_result = '0;
    next_result.valid = 1'b1;
    next_result.op32 = op32;
    next_result.from_gate = use_gate;
    next_result.sp32 = ctrl.stack_big;
    // Push or pop unit follows operand size, also for returns
    next_result.stack_unit = op32 ? COS_UNIT_32 : COS_UNIT_16;
    next_dest = COS_RST_WORD;
    next_ret_addr = COS_RST_WORD;
    case (ctrl.kind)
      COS_KIND_PTR_CALL:
      begin
        // No gate: a 16-bit call only carries a 16-bit offset
        next_dest = op32 ? target : {16'h0000, target[15:0]};
        next_ret_addr = op32 ? cur_ip : {16'h0000, cur_ip[15:0]};
      end
      COS_KIND_GATE_CALL:
      begin
        next_dest = op32 ? gate_ofs : {16'h0000, gate_ofs[15:0]};
        next_ret_addr = op32 ? cur_ip : {16'h0000, cur_ip[15:0]};
        if (ctrl.priv_change)
        begin
          next_result.copy_bytes = op32 ? {ctrl.count, 2'b00} : {1'b0, ctrl.count, 1'b0};
        end
      end
      COS_KIND_INTERRUPT:
      begin
        next_dest = op32 ? gate_ofs : {16'h0000, gate_ofs[15:0]};
        next_ret_addr = op32 ? cur_ip : {16'h0000, cur_ip[15:0]};
        next_result.ret_unsafe = !op32 && (cur_ip > COS_LIMIT_16);
      end
      COS_KIND_RETURN:
      begin
        // Return target is the popped address, cut to the pop width
        next_dest = op32 ? target : {16'h0000, target[15:0]};
      end
      default: ;
    endcase
  end

  // Results; a control write clears valid until the new decode lands
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      result <= cos_result_s'(COS_RST_WORD);
      dest <= COS_RST_WORD;
      ret_addr <= COS_RST_WORD;
    end
    else if (decode_req)
    begin
      result <= next_result;
      dest <= next_dest;
      ret_addr <= next_ret_addr;
    end
    else if (do_write && (aw_addr == COS_OFS_CTRL))
    begin
      result.valid <= 1'b0;
    end
  end

  always_comb
  begin
    read_hit = 1'b1;
    case (i_araddr)
      COS_OFS_CTRL: read_word = 32'(ctrl);
      COS_OFS_TARGET: read_word = target;
      COS_OFS_GATE_OFS: read_word = gate_ofs;
      COS_OFS_IP: read_word = cur_ip;
      COS_OFS_RESULT: read_word = 32'(result);
      COS_OFS_DEST: read_word = dest;
      COS_OFS_RET_ADDR: read_word = ret_addr;
      default:
      begin
        read_word = COS_RST_WORD;
        read_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_arready <= COS_RST_READY;
      o_rvalid <= 1'b0;
      o_rdata <= COS_RST_WORD;
      o_rresp <= COS_RESP_OKAY;
    end
    else if (o_arready && i_arvalid)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= read_word;
      o_rresp <= read_hit ? COS_RESP_OKAY : COS_RESP_SLVERR;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule // cos_call_size_select

// ### bench/cos_call_size_select_props.sv
// Purpose: Port-level checks of the operand-size selector.
// Assumes: AW and W of a control write are taken at one edge.
// Notes: Decode checks fire on reads of the result word only.
`timescale 1ns/1ps
module cos_props
  import cos_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // Bus signals watched
  input wire logic i_awvalid,
  input wire logic [COS_ADDR_W-1:0] i_awaddr,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic [COS_DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic [COS_ADDR_W-1:0] i_araddr,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [COS_DATA_W-1:0] o_rdata,
  input wire logic i_rready
);
  cos_ctrl_s ctrl;
  cos_result_s res;
  logic full;
  logic rd_res;
  logic chk;
  logic wtake;
  assign wtake = i_awvalid && o_awready && i_wvalid && o_wready;
  assign res = cos_result_s'(o_rdata);
  // Partial-lane control writes leave the shadow untrusted
  assign chk = o_rvalid && rd_res && full && res.valid;
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl <= '0;
      full <= 1'b0;
      rd_res <= 1'b0;
    end
    else
    begin
      if (wtake && i_awaddr == COS_OFS_CTRL)
      begin
        ctrl <= cos_ctrl_s'(i_wdata);
        full <= i_wstrb == 4'hF;
      end
      if (i_arvalid && o_arready)
        rd_res <= i_araddr == COS_OFS_RESULT;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  a_ptr_op_size: assert property (chk && ctrl.kind == COS_KIND_PTR_CALL |-> res.op32 == (ctrl.d_flag ^ ctrl.prefix))
    else $error("pointer call size wrong");
  a_ret_op_size: assert property (chk && ctrl.kind == COS_KIND_RETURN |-> res.op32 == (ctrl.d_flag ^ ctrl.prefix))
    else $error("return size wrong");
  a_gate_op_size: assert property (chk && ctrl.kind inside {COS_KIND_GATE_CALL, COS_KIND_INTERRUPT}
    |-> res.op32 == ctrl.gate32 && res.from_gate)
    else $error("gate size wrong");
  a_stack_ptr_width: assert property (chk |-> res.sp32 == ctrl.stack_big)
    else $error("stack pointer width wrong");
  a_param_copy: assert property (chk |-> res.copy_bytes == ((ctrl.kind == COS_KIND_GATE_CALL && ctrl.priv_change) ?
    7'({2'h0, ctrl.count} << (ctrl.gate32 ? 2 : 1)) : 7'h00))
    else $error("copy bytes wrong");
  a_stack_unit: assert property (chk |-> res.stack_unit == (res.op32 ? COS_UNIT_32 : COS_UNIT_16))
    else $error("stack unit wrong");
  a_write_answer: assert property (wtake |=> !o_bvalid ##1 o_bvalid)
    else $error("write answer timing wrong");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  a_read_release: assert property (o_rvalid && i_rready |=> !o_rvalid && o_arready)
    else $error("read not released");
  c_gate_copy: cover property (chk && res.copy_bytes != 7'h00);
  c_unsafe: cover property (chk && res.ret_unsafe);
  c_return: cover property (chk && ctrl.kind == COS_KIND_RETURN);
endmodule // cos_props

bind cos_call_size_select cos_props u_props (.i_clock(i_clock), .i_resetn(i_resetn), .i_awvalid(i_awvalid),
  .i_awaddr(i_awaddr), .o_awready(o_awready), .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .i_rready(i_rready));

// ### bench/cos_call_size_select_test.sv
// Purpose: Self-checking bench for the operand-size selector.
// Assumes: Ready lines held high; one transfer each way at a time.
// Notes: Rows give control, pointer and expected decode words.
`timescale 1ns/1ps
module cos_call_size_select_test
  import cos_pkg::*;
;
  typedef struct packed {
    logic [31:0] ctrl, ip, res, dest, ret;
  } cos_row_s;
  localparam logic [31:0] TGT = 32'h0001_2345;
  localparam logic [31:0] GOFS = 32'h0003_4567;
  localparam logic [31:0] IPH = 32'h0001_0010;
  // Software side: odd word count for the wide gate, prefixed return from wide code, low entry
  cos_row_s rows [11] = '{
    '{32'h0, IPH, 32'h50, 32'h2345, 32'h10},
    '{32'h28, IPH, 32'h93, TGT, IPH},
    '{32'h24, IPH, 32'h93, TGT, IPH},
    '{32'h1D1, IPH, 32'hC95, GOFS, IPH},
    '{32'hFCD, IPH, 32'h3E54, 32'h4567, 32'h10},
    '{32'h2B1, IPH, 32'h97, GOFS, IPH},
    '{32'hC2, IPH, 32'h5C, 32'h4567, 32'h10},
    '{32'h12, IPH, 32'h95, GOFS, IPH},
    '{32'hB, IPH, 32'h91, TGT, 32'h0},
    '{32'h2F, IPH, 32'h52, 32'h2345, 32'h0},
    '{32'h2, 32'hFFFF, 32'h54, 32'h4567, 32'hFFFF}};
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic [3:0] i_wstrb = 4'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, d;
  logic [1:0] e;
  int miscompares = 0;
  int cmp_count = 0;
  always #2 i_clock = ~i_clock;
  cos_call_size_select DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_awvalid(i_awvalid), .i_awaddr(i_awaddr),
    .i_awprot(3'h0), .o_awready(o_awready), .i_wvalid(i_wvalid), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .o_wready(o_wready), .o_bvalid(o_bvalid), .o_bresp(o_bresp), .i_bready(1'b1), .i_arvalid(i_arvalid),
    .i_araddr(i_araddr), .i_arprot(3'h0), .o_arready(o_arready), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_rready(1'b1));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready is judged at the falling edge so the rising edge never races it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= v;
    i_wstrb <= s;
    while (pa || pw)
    begin
      @(negedge i_clock);
      pa = pa && !o_awready;
      pw = pw && !o_wready;
      @(posedge i_clock);
      i_awvalid <= pa;
      i_wvalid <= pw;
    end
    do @(negedge i_clock); while (!o_bvalid);
    check({30'h0, o_bresp}, {30'h0, r});
    @(posedge i_clock);
  endtask
  task automatic rd(input logic [7:0] a);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    do @(negedge i_clock); while (!o_arready);
    @(posedge i_clock);
    i_arvalid <= 1'b0;
    do @(negedge i_clock); while (!o_rvalid);
    d = o_rdata;
    e = o_rresp;
    @(posedge i_clock);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    results();
  end
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_resetn <= 1'b1;
    wr(COS_OFS_TARGET, TGT, 4'hF, COS_RESP_OKAY);
    wr(COS_OFS_GATE_OFS, GOFS, 4'hF, COS_RESP_OKAY);
    for (int k = 0; k < 11; k++)
    begin
      wr(COS_OFS_IP, rows[k].ip, 4'hF, COS_RESP_OKAY);
      wr(COS_OFS_CTRL, rows[k].ctrl, 4'hF, COS_RESP_OKAY);
      repeat (2) @(posedge i_clock);
      rd(COS_OFS_RESULT);
      check(d, rows[k].res);
      rd(COS_OFS_DEST);
      check(d, rows[k].dest);
      rd(COS_OFS_RET_ADDR);
      check(d, rows[k].ret);
      $display("row %0d done", k);
    end
    // Read-only word keeps the last decode
    wr(COS_OFS_RESULT, 32'hFFFF_FFFF, 4'hF, COS_RESP_OKAY);
    rd(COS_OFS_RESULT);
    check(d, 32'h54);
    wr(COS_OFS_CTRL, 32'hFFFF_FFFF, 4'hF, COS_RESP_OKAY);
    wr(COS_OFS_CTRL, 32'h0, 4'h2, COS_RESP_OKAY);
    rd(COS_OFS_CTRL);
    check(d, 32'h0FF);
    wr(8'h1C, 32'h1, 4'hF, COS_RESP_SLVERR);
    rd(8'h02);
    check(d, 32'h0);
    check({30'h0, e}, {30'h0, COS_RESP_SLVERR});
    $display("access test done");
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    rd(COS_OFS_CTRL);
    check(d, COS_RST_WORD);
    rd(COS_OFS_RESULT);
    check(d, COS_RST_WORD);
    $display("reset test done");
    results();
  end
endmodule // cos_call_size_select_test
